// ### stg_pkg.sv
package stg_pkg;

    // ========================================================
    // Datapath widths
    localparam int WORD_W  = 16;
    localparam int BYTE_W  = 8;
    localparam int GUARD_W = 4;
    localparam int CNT_W   = 8;
    localparam int UWORD_W = 38;

    // ========================================================
    // Microword field positions
    localparam int UW_S1_LO  = 20;
    localparam int UW_S1_HI  = 22;
    localparam int UW_S2_BIT = 23;
    localparam int UW_S3_LO  = 36;
    localparam int UW_S3_HI  = 37;
    localparam int S1_LOWSEL = 2;    // Stage-one bit steering the low half
    localparam int NIBBLE    = 4;    // Second-stage shift distance
    localparam int LOW_TAP   = 3;    // First-stage bit caught on right four
    localparam int HI_TAP    = 7;    // Data bit caught on right eight

    // ========================================================
    // Selection codes
    typedef enum logic [2:0] {
        S1_DIRECT  = 3'h0,
        S1_LO_DUP  = 3'h1,
        S1_FILL_LO = 3'h2,
        S1_CNT_LO  = 3'h3,
        S1_HI_DUP  = 3'h4,
        S1_SWAP    = 3'h5,
        S1_FILL_HI = 3'h6,
        S1_CNT_HI  = 3'h7
    } stg_s1_t;

    typedef enum logic {
        S2_PASS   = 1'h0,
        S2_RIGHT4 = 1'h1
    } stg_s2_t;

    typedef enum logic [1:0] {
        S3_LEFT1  = 2'h0,
        S3_PASS   = 2'h1,
        S3_RIGHT1 = 2'h2,
        S3_RIGHT2 = 2'h3
    } stg_s3_t;

    typedef struct packed {
        stg_s1_t s1;
        stg_s2_t s2;
        stg_s3_t s3;
    } stg_sel_t;

    // Shift word modes, as seen on the S1/S0 controls
    typedef enum logic [1:0] {
        SR_HOLD  = 2'h0,
        SR_RIGHT = 2'h1,
        SR_LEFT  = 2'h2,
        SR_LOAD  = 2'h3
    } stg_sr_mode_t;

    // Residual image, kept exactly as loaded from bus B bits 14:11
    typedef struct packed {
        logic end_s2_n;
        logic mode1_n;
        logic mode0_n;
        logic guard_en;
    } stg_res_t;

    localparam logic [GUARD_W-1:0] RES_RST = 4'h0;

    // ========================================================
    // Bus map
    localparam int         OFS_W       = 8;
    localparam logic [7:0] OFS_RES     = 8'h00;
    localparam logic [7:0] OFS_SHIFT   = 8'h04;
    localparam logic [7:0] OFS_RESULT  = 8'h08;
    localparam logic       HRESP_OKAY  = 1'h0;

    // ========================================================
    // Residual decoding
    function automatic stg_sr_mode_t stg_sr_mode(input stg_res_t r);
        return stg_sr_mode_t'({~r.mode1_n, ~r.mode0_n});
    endfunction

    function automatic logic stg_end_s2(input stg_res_t r);
        return ~r.end_s2_n;
    endfunction

endpackage

// ### stg_seq_model.sv
`timescale 1ns/1ps

// ========================================================
// Sequencer and ALU side of the shift tree
module stg_seq_model (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic [stg_pkg::UWORD_W-1:0]  nxt_uword,
    input  wire logic [stg_pkg::WORD_W-1:0]   nxt_data,
    input  wire logic                         nxt_carry,
    input  wire logic [stg_pkg::CNT_W-1:0]    nxt_count,
    input  wire logic [stg_pkg::WORD_W-1:0]   nxt_alu,
    input  wire logic                         nxt_strobe,
    input  wire logic                         nxt_res_load,
    input  wire logic [stg_pkg::GUARD_W-1:0]  nxt_res_b,
    input  wire logic                         nxt_loop,
    input  wire logic [stg_pkg::WORD_W-1:0]   a_bus,
    output logic [stg_pkg::UWORD_W-1:0]       microword,
    output logic [stg_pkg::WORD_W-1:0]        work_data,
    output logic                              carry,
    output logic [stg_pkg::CNT_W-1:0]         loop_counter,
    output logic [stg_pkg::WORD_W-1:0]        alu_result,
    output logic                              shift_word_clock_enable,
    output logic                              res_load,
    output logic [stg_pkg::GUARD_W-1:0]       res_bus_b
);
    import stg_pkg::*;

    // Controls change only at an edge, one microcycle ahead of their use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            microword               <= '0;
            work_data               <= '0;
            carry                   <= 1'b0;
            loop_counter            <= '0;
            alu_result              <= '0;
            shift_word_clock_enable <= 1'b0;
            res_load                <= 1'b0;
            res_bus_b               <= '0;
        end else begin
            microword               <= nxt_uword;     // No constant pad use here
            carry                   <= nxt_carry;
            loop_counter            <= nxt_count;
            alu_result              <= nxt_alu;
            shift_word_clock_enable <= nxt_strobe;
            res_load                <= nxt_res_load;
            res_bus_b               <= nxt_res_b;
            // Operand stands in D a whole microcycle before the shift
            if (!nxt_loop) begin
                work_data <= nxt_data;
            end else if (shift_word_clock_enable) begin
                work_data <= a_bus;                   // D and shift word clocked together
            end
        end
    end
endmodule

// ### stg_shift_tree.sv
`timescale 1ns/1ps

module stg_shift_tree (
    input  wire logic [stg_pkg::WORD_W-1:0] work_data,
    input  wire logic                       carry,
    input  wire logic [stg_pkg::CNT_W-1:0]  loop_counter,
    input  wire stg_pkg::stg_sel_t          sel,
    input  wire logic                       sr_msb,
    input  wire logic                       end_s2,
    output logic [stg_pkg::WORD_W-1:0]      first_out,
    output logic [stg_pkg::WORD_W-1:0]      second_out,
    output logic [stg_pkg::WORD_W-1:0]      third_out,
    output logic                            shift_end
);
    import stg_pkg::*;

    logic [BYTE_W-1:0] d_hi;
    logic [BYTE_W-1:0] d_lo;
    logic [BYTE_W-1:0] first_stage_high_half;
    logic [BYTE_W-1:0] first_stage_low_half;
    logic [BYTE_W-1:0] fill_byte;
    logic              low_sel;

    // ========================================================
    // First stage: byte steering, no storage anywhere
    assign d_hi      = work_data[WORD_W-1:BYTE_W];
    assign d_lo      = work_data[BYTE_W-1:0];
    assign fill_byte = {BYTE_W{carry}};
    assign low_sel   = sel.s1[S1_LOWSEL];
    assign first_stage_low_half = low_sel ? d_hi : d_lo;
    assign first_stage_high_half =
        (sel.s1 == S1_DIRECT)  ? d_hi :
        (sel.s1 == S1_LO_DUP)  ? d_lo :
        (sel.s1 == S1_FILL_LO) ? fill_byte :
        (sel.s1 == S1_CNT_LO)  ? loop_counter :
        (sel.s1 == S1_HI_DUP)  ? d_hi :
        (sel.s1 == S1_SWAP)    ? d_lo :
        (sel.s1 == S1_FILL_HI) ? fill_byte : loop_counter;
    assign first_out = {first_stage_high_half, first_stage_low_half};

    // ========================================================
    // Second stage: pass or right four with carry fill
    assign second_out = (sel.s2 == S2_RIGHT4) ?
        {{NIBBLE{carry}}, first_out[WORD_W-1:NIBBLE]} : first_out;

    // ========================================================
    // Shift-end select comes from stage selects and residual, not the word
    // Priority: right-four catch, then right-eight catch, then shift word
    assign shift_end =
        (sel.s2 == S2_RIGHT4) ? first_out[LOW_TAP] :
        low_sel               ? work_data[HI_TAP] :
        !end_s2               ? sr_msb :
                                1'b0;

    // ========================================================
    // Third stage; ends are discarded, never wrapped round
    assign third_out =
        (sel.s3 == S3_LEFT1)  ? {second_out[WORD_W-2:0], shift_end} :
        (sel.s3 == S3_PASS)   ? second_out :
        (sel.s3 == S3_RIGHT1) ? {carry, second_out[WORD_W-1:1]} :
                                {{2{carry}}, second_out[WORD_W-1:2]};

endmodule

// ### stg_shift_unit.sv
// Functional notes
// - Three cascaded combinational stages, same microcycle
// - No rotation; shifted-out bits are discarded
// - Stage selects from microword bits directly
// - Codes 0-3: direct, low dup, fill, counter
// - Codes 4-7: high dup, swap, fill, counter
// - Stage two passes or shifts right four
// - Stage three: left, pass, right one, two
// - Shift-end selects from stage selects and residual
// - Right-eight low half, no right four: bit seven
// - Right four with left one feeds bit three
// - Guard has shift register modes, residual enabled
// - Parallel load clears the guard
// - Right shift: stage two bit zero enters
// - Left shift: guard or carry enters bit zero
// - Guard bits three, two exported as conditions
// - Data and shift word form 32-bit pair
// - Residual select low, stages passing: msb feeds
// - Guard shifts only when residual enables it; load clears it either way
`timescale 1ns/1ps

module stg_shift_unit #(
    parameter int ADDR_W = 32
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [ADDR_W-1:0]            haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    input  wire logic [stg_pkg::UWORD_W-1:0]  microword,
    input  wire logic [stg_pkg::WORD_W-1:0]   work_data,
    input  wire logic                         carry,
    input  wire logic [stg_pkg::CNT_W-1:0]    loop_counter,
    input  wire logic [stg_pkg::WORD_W-1:0]   alu_result,
    input  wire logic                         shift_word_clock_enable,
    input  wire logic                         res_load,
    input  wire logic [stg_pkg::GUARD_W-1:0]  res_bus_b,
    output logic [stg_pkg::WORD_W-1:0]        a_bus,
    output logic [stg_pkg::WORD_W-1:0]        shift_word_reg,
    output logic [1:0]                        guard_cond
);
    import stg_pkg::*;

    // ========================================================
    // Elaboration checks
    generate
        if (ADDR_W < OFS_W) begin : g_bad_addr
            $error("ADDR_W too narrow for the register map");
        end
    endgenerate

    // ========================================================
    // Declarations
    stg_sel_t             sel;
    stg_res_t             residual_control_reg;
    stg_sr_mode_t         sr_mode;
    logic [GUARD_W-1:0]   res_q;
    logic [GUARD_W-1:0]   res_d;
    logic [WORD_W-1:0]    sr_q;
    logic [WORD_W-1:0]    sr_d;
    logic [WORD_W-1:0]    sr_right;
    logic [WORD_W-1:0]    sr_left;
    logic [GUARD_W-1:0]   guard_q;
    logic [GUARD_W-1:0]   guard_d;
    logic                 guard_en;
    logic                 left_in;
    logic [WORD_W-1:0]    first_out;
    logic [WORD_W-1:0]    second_out;
    logic [WORD_W-1:0]    third_out;
    logic                 shift_end_mux;
    logic                 ahb_go;
    logic                 ahb_rd;
    logic                 ahb_wr;
    logic [OFS_W-1:0]     addr_ofs;
    logic                 wr_pend_q;
    logic [OFS_W-1:0]     wr_ofs_q;
    logic                 sw_res_wr;
    logic [31:0]          rd_word;
    logic [31:0]          hrdata_q;
    logic                 hreadyout_q;

    // ========================================================
    // Microword field extraction; bits go straight to the stage selects
    // One driver for the whole select struct; fields in s1, s2, s3 order
    assign sel = {microword[UW_S1_HI:UW_S1_LO],
                  microword[UW_S2_BIT],
                  microword[UW_S3_HI:UW_S3_LO]};

    // ========================================================
    // Residual decode
    assign residual_control_reg = stg_res_t'(res_q);
    assign sr_mode  = stg_sr_mode(residual_control_reg);
    assign guard_en = residual_control_reg.guard_en;

    // ========================================================
    // Shift tree; the A-side bus is not registered so the result
    // still reaches the ALU within the same microcycle
    stg_shift_tree u_tree (
        .work_data    (work_data),
        .carry        (carry),
        .loop_counter (loop_counter),
        .sel          (sel),
        .sr_msb       (sr_q[WORD_W-1]),
        .end_s2       (stg_end_s2(residual_control_reg)),
        .first_out    (first_out),
        .second_out   (second_out),
        .third_out    (third_out),
        .shift_end    (shift_end_mux)
    );
    assign a_bus = third_out;

    // ========================================================
    // Shift word and guard next values
    assign left_in  = guard_en ? guard_q[GUARD_W-1] : carry;
    assign sr_right = {second_out[0], sr_q[WORD_W-1:1]};
    assign sr_left  = {sr_q[WORD_W-2:0], left_in};
    assign sr_d =
        (sr_mode == SR_RIGHT) ? sr_right :
        (sr_mode == SR_LEFT)  ? sr_left :
        (sr_mode == SR_LOAD)  ? alu_result : sr_q;
    // Load clears the guard even when disabled, so stale extension
    // bits never leak into a fresh operand
    assign guard_d =
        (sr_mode == SR_LOAD)             ? '0 :
        (!guard_en)                      ? guard_q :
        (sr_mode == SR_RIGHT)            ? {sr_q[0], guard_q[GUARD_W-1:1]} :
        (sr_mode == SR_LEFT)             ? {guard_q[GUARD_W-2:0], 1'b0} :
                                           guard_q;

    // Shift word and guard clock on the same strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sr_q    <= '0;
            guard_q <= '0;
        end else if (shift_word_clock_enable) begin
            sr_q    <= sr_d;
            guard_q <= guard_d;
        end
    end

    assign shift_word_reg = sr_q;
    assign guard_cond     = guard_q[GUARD_W-1:GUARD_W-2];

    // ========================================================
    // Residual register: datapath load beats a same-cycle bus write
    assign res_d = res_load  ? res_bus_b :
                   sw_res_wr ? hwdata[GUARD_W-1:0] : res_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_q <= RES_RST;
        end else begin
            res_q <= res_d;
        end
    end

    // ========================================================
    // Bus slave decode; zero wait states, always OKAY
    assign ahb_go    = hsel & htrans[1] & hready;
    assign ahb_rd    = ahb_go & ~hwrite;
    assign ahb_wr    = ahb_go & hwrite;
    assign addr_ofs  = haddr[OFS_W-1:0];
    assign sw_res_wr = wr_pend_q & (wr_ofs_q == OFS_RES);
    // Unmapped offsets read zero and ignore writes
    assign rd_word =
        (addr_ofs == OFS_RES)    ? {28'h0, res_q} :
        (addr_ofs == OFS_SHIFT)  ? {12'h0, guard_q, sr_q} :
        (addr_ofs == OFS_RESULT) ? {16'h0, third_out} : 32'h0;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q  <= '0;
        end else begin
            wr_pend_q <= ahb_wr;
            wr_ofs_q  <= addr_ofs;
        end
    end

    // Read data launched for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q    <= '0;
            hreadyout_q <= 1'b0;
        end else begin
            hrdata_q    <= ahb_rd ? rd_word : 32'h0;
            hreadyout_q <= 1'b1;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = HRESP_OKAY;

    // ========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_strobe_right;
        shift_word_clock_enable && sr_mode == SR_RIGHT;
    endsequence

    sequence s_strobe_left;
        shift_word_clock_enable && sr_mode == SR_LEFT && !res_load;
    endsequence

    a_tree_direct_path: assert property (
        sel.s1 == S1_DIRECT && sel.s2 == S2_PASS && sel.s3 == S3_PASS
        |-> a_bus == work_data)
        else $error("direct path does not pass data word");

    a_right_no_wrap: assert property (
        sel.s1 == S1_DIRECT && sel.s2 == S2_PASS && sel.s3 == S3_RIGHT2
        |-> a_bus[WORD_W-1:WORD_W-2] == {2{carry}})
        else $error("right shift wrapped low bits to top");

    a_swap_bytes: assert property (
        sel.s1 == S1_SWAP && sel.s2 == S2_PASS && sel.s3 == S3_PASS
        |-> a_bus == {work_data[BYTE_W-1:0], work_data[WORD_W-1:BYTE_W]})
        else $error("byte exchange wrong");

    a_counter_high: assert property (
        sel.s1 == S1_CNT_LO && sel.s2 == S2_RIGHT4 && sel.s3 == S3_PASS
        |-> a_bus == {{NIBBLE{carry}}, loop_counter, work_data[BYTE_W-1:NIBBLE]})
        else $error("counter insertion or right four wrong");

    a_end_bit_seven: assert property (
        sel.s1 == S1_FILL_HI && sel.s2 == S2_PASS && sel.s3 == S3_LEFT1
        |-> a_bus == {{7{carry}}, work_data[WORD_W-1:HI_TAP]})
        else $error("right seven result wrong");

    a_end_bit_three: assert property (
        sel.s1 == S1_DIRECT && sel.s2 == S2_RIGHT4 && sel.s3 == S3_LEFT1
        |-> a_bus == {{3{carry}}, work_data[WORD_W-1:LOW_TAP]})
        else $error("right three result wrong");

    a_end_from_sr: assert property (
        sel.s1 == S1_DIRECT && sel.s2 == S2_PASS && sel.s3 == S3_LEFT1
        && !stg_end_s2(residual_control_reg)
        |-> a_bus == {work_data[WORD_W-2:0], sr_q[WORD_W-1]})
        else $error("shift word msb not fed to low bit");

    a_end_default_zero: assert property (
        !sel.s1[S1_LOWSEL] && sel.s2 == S2_PASS && sel.s3 == S3_LEFT1
        && stg_end_s2(residual_control_reg) |-> a_bus[0] == 1'b0)
        else $error("shift-end default not zero");

    a_sr_right_step: assert property (
        s_strobe_right ##1 1'b1
        |-> sr_q == {$past(second_out[0]), $past(sr_q[WORD_W-1:1])})
        else $error("shift word right step wrong");

    a_pair_left_step: assert property (
        s_strobe_left |=> sr_q == {$past(sr_q[WORD_W-2:0]),
            $past(guard_en) ? $past(guard_q[GUARD_W-1]) : $past(carry)})
        else $error("shift word left step wrong");

    a_guard_load_clear: assert property (
        shift_word_clock_enable && sr_mode == SR_LOAD |=> guard_q == '0)
        else $error("guard not cleared on load");

    a_guard_hold_off: assert property (
        shift_word_clock_enable && !guard_en && sr_mode != SR_LOAD
        |=> $stable(guard_q))
        else $error("disabled guard changed");

    a_guard_cond_out: assert property (
        shift_word_clock_enable && sr_mode == SR_RIGHT && guard_en
        |=> guard_cond == {$past(sr_q[0]), $past(guard_q[GUARD_W-1])})
        else $error("guard condition bits wrong");

endmodule

// ### testbench.sv
`timescale 1ns/1ps

module testbench;
    import stg_pkg::*;

    // ========================================================
    // Signals
    logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]         haddr, hwdata, hrdata, seed, rd;
    logic [1:0]          htrans, gcond;
    logic [2:0]          hsize;
    logic [UWORD_W-1:0]  n_uw, uw;
    logic [WORD_W-1:0]   n_d, wd, n_alu, alu, a_bus, swr, sr_m, b_exp, a_exp;
    logic                n_c, c, n_stb, stb, n_rl, rl, n_loop, chk_on;
    logic [CNT_W-1:0]    n_cnt, cnt;
    logic [3:0]          n_rb, rb, gd_m, res_m;
    int                  err_count, checked;

    // ========================================================
    // Expected shifter behaviour
    function automatic logic [15:0] second_ref(input logic [37:0] u, input logic [15:0] d,
                                               input logic cc, input logic [7:0] k);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [15:0] a;
        lo = u[22] ? d[15:8] : d[7:0];
        case (u[21:20])
            2'h0: hi = d[15:8];
            2'h1: hi = d[7:0];
            2'h2: hi = {8{cc}};
            default: hi = k;
        endcase
        a = {hi, lo};
        return u[23] ? {{4{cc}}, a[15:4]} : a;
    endfunction

    function automatic logic [15:0] tree_ref(input logic [37:0] u, input logic [15:0] d,
                                             input logic cc, input logic [7:0] k,
                                             input logic sr15, input logic sel2_low);
        logic [15:0] b;
        logic [15:0] a;
        logic        se;
        b = second_ref(u, d, cc, k);
        a = second_ref({u[37:24], 1'b0, u[22:0]}, d, cc, k);
        se = u[23] ? a[3] : (u[22] ? d[7] : (sel2_low ? sr15 : 1'b0));
        case (u[37:36])
            2'h0: return {b[14:0], se};
            2'h1: return b;
            2'h2: return {cc, b[15:1]};
            default: return {{2{cc}}, b[15:2]};
        endcase
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0);
    endfunction

    assign b_exp = second_ref(uw, wd, c, cnt);
    assign a_exp = tree_ref(uw, wd, c, cnt, sr_m[15], res_m[3]);

    // ========================================================
    // Design, partner and clock
    stg_shift_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .microword(uw),
        .work_data(wd), .carry(c), .loop_counter(cnt), .alu_result(alu),
        .shift_word_clock_enable(stb), .res_load(rl), .res_bus_b(rb), .a_bus(a_bus),
        .shift_word_reg(swr), .guard_cond(gcond));

    stg_seq_model seq (.hclk(hclk), .hresetn(hresetn), .nxt_uword(n_uw), .nxt_data(n_d),
        .nxt_carry(n_c), .nxt_count(n_cnt), .nxt_alu(n_alu), .nxt_strobe(n_stb),
        .nxt_res_load(n_rl), .nxt_res_b(n_rb), .nxt_loop(n_loop), .a_bus(a_bus),
        .microword(uw), .work_data(wd), .carry(c), .loop_counter(cnt), .alu_result(alu),
        .shift_word_clock_enable(stb), .res_load(rl), .res_bus_b(rb));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ========================================================
    // Reference shift word, guard and residual; mode sampled at the strobe edge
    always @(posedge hclk) begin
        if (!hresetn) begin
            sr_m  <= '0;
            gd_m  <= '0;
            res_m <= '0;
        end else begin
            if (stb === 1'b1) begin
                case ({~res_m[2], ~res_m[1]})
                    2'b01: begin
                        sr_m <= {b_exp[0], sr_m[15:1]};
                        if (res_m[0]) gd_m <= {sr_m[0], gd_m[3:1]};
                    end
                    2'b10: begin
                        sr_m <= {sr_m[14:0], res_m[0] ? gd_m[3] : c};
                        if (res_m[0]) gd_m <= {gd_m[2:0], 1'b0};
                    end
                    2'b11: begin
                        sr_m <= alu;
                        gd_m <= 4'h0;
                    end
                    default: ;
                endcase
            end
            if (rl === 1'b1) res_m <= rb;
        end
    end

    // Settled outputs compared every cycle
    always @(negedge hclk) begin
        if (chk_on) begin
            check({16'h0, a_bus}, {16'h0, a_exp});
            check({16'h0, swr}, {16'h0, sr_m});
            check({30'h0, gcond}, {30'h0, gd_m[3:2]});
        end
    end

    // ========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                $display("CHECK FAILED at %0t: bus wait ran out", $time);
                summarize();
            end
            @(posedge hclk);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= v;
        wait_rdy();
        r = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
        if (wr && a == OFS_RES) res_m = v[3:0];
    endtask

    task automatic step(input logic [37:0] u, input logic [15:0] d, input logic cc,
                        input logic s, input logic l, input logic [3:0] b);
        @(posedge hclk);
        n_uw  <= u;
        n_d   <= d;
        n_c   <= cc;
        n_stb <= s;
        n_rl  <= l;
        n_rb  <= b;
    endtask

    // ========================================================
    // Main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; n_uw = '0; n_d = '0; n_c = 1'b0; n_cnt = '0;
        n_alu = '0; n_stb = 1'b0; n_rl = 1'b0; n_rb = '0; n_loop = 1'b0; chk_on = 1'b0;
        seed = 32'h2b32; err_count = 0; checked = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_on = 1'b1;
        // Reset images, read-only and unmapped places
        ahb(1'b0, OFS_RES, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b1, OFS_SHIFT, 32'hffff_ffff, rd);
        ahb(1'b0, OFS_SHIFT, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b1, 8'h0c, 32'h1234_5678, rd);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b1, OFS_RES, 32'hffff_fffb, rd);
        ahb(1'b0, OFS_RES, 32'h0, rd);
        check(rd, 32'h0000_000b);
        // Every stage code with both carry values; right 3, 7 and 11 among them
        for (int i = 0; i < 128; i++) begin
            seed = lfsr(seed);
            step({i[4:3], 12'h0, i[6], i[2:0], seed[19:0]}, seed[31:16], i[5], 1'b0, 1'b0, 4'h0);
        end
        step({2'h0, 13'h0, 3'h6, 20'h0}, 16'h8f1e, 1'b1, 1'b0, 1'b0, 4'h0);
        ahb(1'b0, OFS_RESULT, 32'h0, rd);
        check(rd, {16'h0, a_exp});
        // 32-bit left step: load, then left with guard and shift-word feed
        n_alu <= 16'h9c35;
        step(38'h0, 16'ha5c3, 1'b0, 1'b0, 1'b1, 4'b0000);
        step(38'h0, 16'ha5c3, 1'b0, 1'b1, 1'b0, 4'b0000);
        step(38'h0, 16'ha5c3, 1'b1, 1'b0, 1'b1, 4'b1011);
        // Gap so the load strobe never shifts D as well
        step(38'h0, 16'ha5c3, 1'b1, 1'b0, 1'b0, 4'h0);
        n_loop <= 1'b1;
        repeat (5) step(38'h0, 16'h0, 1'b1, 1'b1, 1'b0, 4'h0);
        repeat (3) step(38'h0, 16'h0, 1'b1, 1'b0, 1'b0, 4'h0);
        check({wd, swr}, 32'ha5c3_9c35 << 5);
        n_loop <= 1'b0;
        // Random traffic with random residual loads and strobes
        for (int i = 0; i < 600; i++) begin
            seed = lfsr(seed);
            rd = lfsr(seed ^ 32'h5a5a_0f0f);
            n_cnt <= rd[23:16];
            n_alu <= rd[15:0];
            step({rd[31:26], seed}, seed[31:16] ^ rd[15:0], rd[24], seed[3],
                 rd[27:25] == 3'h0, rd[31:28]);
        end
        step(38'h0, 16'h0, 1'b0, 1'b0, 1'b0, 4'h0);
        repeat (2) @(posedge hclk);
        summarize();
    end
endmodule
